// >>> rtl/mqp_pkg.sv
package mqp_pkg;

  // Bus and pointer widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int OFS_W = 18;
  localparam int BASE_W = 12;
  localparam int NUM_Q = 4;

  // Register byte offsets
  localparam logic [11:0] CS_OFFSET = 12'h200;
  localparam logic [11:0] IN_FREE_TOP_OFFSET = 12'h204;
  localparam logic [11:0] IN_FREE_BOT_OFFSET = 12'h208;
  localparam logic [11:0] IN_POST_TOP_OFFSET = 12'h20c;
  localparam logic [11:0] IN_POST_BOT_OFFSET = 12'h210;
  localparam logic [11:0] OUT_FREE_TOP_OFFSET = 12'h214;
  localparam logic [11:0] OUT_FREE_BOT_OFFSET = 12'h218;
  localparam logic [11:0] OUT_POST_TOP_OFFSET = 12'h21c;
  localparam logic [11:0] OUT_POST_BOT_OFFSET = 12'h220;

  // Field positions in the control and status word
  localparam int BASE_LSB = 20;
  localparam int OFS_LSB = 2;
  localparam int EMPTY_LSB = 12;
  localparam int FULL_LSB = 8;
  localparam int DEPTH_LSB = 4;
  localparam int RDMODE_BIT = 1;
  localparam int ACCESS_BIT = 0;

  // Values after reset
  localparam logic [11:0] BASE_RESET = 12'h000;
  localparam logic [17:0] OFS_RESET = 18'h00000;
  localparam logic [2:0] DEPTH_RESET = 3'h0;
  localparam logic RDMODE_RESET = 1'b0;
  localparam logic ACCESS_RESET = 1'b0;
  localparam logic [31:0] ALL_ONES = 32'hffffffff;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // Queue indices; the request kind equals the queue index
  localparam logic [1:0] Q_IN_FREE = 2'h0;
  localparam logic [1:0] Q_IN_POST = 2'h1;
  localparam logic [1:0] Q_OUT_FREE = 2'h2;
  localparam logic [1:0] Q_OUT_POST = 2'h3;

  // Depth selector codes
  typedef enum logic [2:0] {
    DEPTH_256 = 3'h0,
    DEPTH_1K = 3'h1,
    DEPTH_4K = 3'h2,
    DEPTH_16K = 3'h3,
    DEPTH_64K = 3'h4
  } mqp_depth_type;

  // Queue port request and answer
  typedef struct packed {
    logic valid;
    logic [1:0] queue;
  } mqp_q_req_type;

  typedef struct packed {
    logic done;
    logic ignored;
    logic [31:0] addr;
  } mqp_q_ans_type;

  // Word offset mask of one queue for a depth code
  function automatic logic [17:0] mqp_depth_mask(input logic [2:0] code);
    case (code)
      DEPTH_256: mqp_depth_mask = 18'h000ff;
      DEPTH_1K: mqp_depth_mask = 18'h003ff;
      DEPTH_4K: mqp_depth_mask = 18'h00fff;
      DEPTH_16K: mqp_depth_mask = 18'h03fff;
      DEPTH_64K: mqp_depth_mask = 18'h0ffff;
      default: mqp_depth_mask = 18'h000ff;
    endcase
  endfunction

  // Memory address of an entry: base, offset, two zero bits
  function automatic logic [31:0] mqp_entry_addr(input logic [11:0] base, input logic [17:0] ofs);
    mqp_entry_addr = {base, ofs, 2'b00};
  endfunction

endpackage

// >>> rtl/mqp_ptr_calc.sv
`timescale 1ns/1ps
module mqp_ptr_calc (
  input wire logic [2:0] depth,
  input wire logic [17:0] top,
  input wire logic [17:0] bottom,
  output logic [17:0] next_top,
  output logic [17:0] next_bottom,
  output logic empty,
  output logic full
);
  import mqp_pkg::*;

  logic [17:0] mask;
  logic [17:0] top_inc;
  logic [17:0] bot_inc;

  // One common size for all queues
  assign mask = mqp_depth_mask(depth);
  assign top_inc = top + 18'h00001;
  assign bot_inc = bottom + 18'h00001;

  // Step by one word, wrapping inside the selected size
  assign next_top = (top & ~mask) | (top_inc & mask);
  assign next_bottom = (bottom & ~mask) | (bot_inc & mask);

  // Equal pointers mean empty; one step short means full
  assign empty = (top == bottom);
  assign full = (next_top == bottom);
endmodule

// >>> rtl/mqp_regs.sv
// Operation
// - Writable base address of the four equal queues, held in bits 31:20.
// - Four read-only empty flags, one per queue, set after reset.
// - Four read-only full flags, one per queue, clear after reset.
// - Depth code picks 256, 1K, 4K, 16K or 64K entries; others reserved.
// - All four queues share one size; every entry is 32 bits.
// - Bottom-read mode 0 returns the bottom pointer value.
// - Mode 1 returns all ones when top equals bottom, else the pointer.
// - Access bit 1 ignores queue port writes and returns all ones on reads.
// - Device advances inbound free bottom by four, wrapping at queue size.
// - Each pointer register mirrors the base address in its upper bits.
// - Device advances inbound post top by four, modulo queue size.
// - Device advances outbound free top by four, modulo queue size.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module mqp_regs #(
  parameter int ADDR_BITS = mqp_pkg::ADDR_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_BITS-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire mqp_pkg::mqp_q_req_type q_req,
  output mqp_pkg::mqp_q_ans_type q_ans,
  output logic [3:0] queue_empty,
  output logic [3:0] queue_full
);
  import mqp_pkg::*;

  // Control state
  logic [11:0] queue_region_base;
  logic [2:0] depth_code;
  logic bottom_read_mode;
  logic queue_access_control;

  // Pointer storage, indexed by queue
  logic [17:0] top_ptr [NUM_Q];
  logic [17:0] bot_ptr [NUM_Q];
  logic [17:0] next_top_ptr [NUM_Q];
  logic [17:0] next_bot_ptr [NUM_Q];
  logic [3:0] empty_flag;
  logic [3:0] full_flag;

  // Register decode
  logic cs_hit;
  logic ptr_hit;
  logic ptr_is_bottom;
  logic [1:0] ptr_index;
  logic [11:0] offset_word;

  // Queue port decode
  logic q_enabled;
  logic q_is_pop;
  logic q_blocked;
  logic [3:0] advance_top;
  logic [3:0] advance_bot;
  logic [31:0] q_entry;
  logic [31:0] next_rdata;
  mqp_q_ans_type next_ans;
  logic q_accept;

  // Host side strobes and views
  logic cs_write;
  logic [17:0] host_ofs;
  logic [3:0] host_wr_top;
  logic [3:0] host_wr_bot;
  logic [31:0] status_word;
  logic [31:0] bottom_view;

  // Flag field order puts the inbound free queue in the top bit
  function automatic logic [3:0] flag_field(input logic [3:0] flags);
    flag_field = {flags[0], flags[1], flags[2], flags[3]};
  endfunction

  // Free-in and post-out hand entries out from their bottoms
  function automatic logic queue_pops(input logic [1:0] q);
    queue_pops = (q == Q_IN_FREE) || (q == Q_OUT_POST);
  endfunction

  // Equal pointers hide the bottom value when the read mode asks for it
  function automatic logic [31:0] bottom_read_value(input logic mode, input logic same, input logic [31:0] entry);
    if (mode && same) begin
      bottom_read_value = ALL_ONES;
    end else begin
      bottom_read_value = entry;
    end
  endfunction

  // Pointer maths for each queue
  generate
    for (genvar qi = 0; qi < NUM_Q; qi++) begin : g_queue
      mqp_ptr_calc u_calc (
        .depth(depth_code),
        .top(top_ptr[qi]),
        .bottom(bot_ptr[qi]),
        .next_top(next_top_ptr[qi]),
        .next_bottom(next_bot_ptr[qi]),
        .empty(empty_flag[qi]),
        .full(full_flag[qi])
      );
    end
  endgenerate

  // Flags to ports; bit order matches queue index
  assign queue_empty = empty_flag;
  assign queue_full = full_flag;

  // Address decode of the register window
  always_comb begin
    offset_word = 12'(reg_addr);
    cs_hit = (offset_word == CS_OFFSET);
    ptr_hit = 1'b0;
    ptr_is_bottom = 1'b0;
    ptr_index = Q_IN_FREE;
    case (offset_word)
      IN_FREE_TOP_OFFSET: begin
        ptr_hit = 1'b1;
        ptr_index = Q_IN_FREE;
      end
      IN_FREE_BOT_OFFSET: begin
        ptr_hit = 1'b1;
        ptr_is_bottom = 1'b1;
        ptr_index = Q_IN_FREE;
      end
      IN_POST_TOP_OFFSET: begin
        ptr_hit = 1'b1;
        ptr_index = Q_IN_POST;
      end
      IN_POST_BOT_OFFSET: begin
        ptr_hit = 1'b1;
        ptr_is_bottom = 1'b1;
        ptr_index = Q_IN_POST;
      end
      OUT_FREE_TOP_OFFSET: begin
        ptr_hit = 1'b1;
        ptr_index = Q_OUT_FREE;
      end
      OUT_FREE_BOT_OFFSET: begin
        ptr_hit = 1'b1;
        ptr_is_bottom = 1'b1;
        ptr_index = Q_OUT_FREE;
      end
      OUT_POST_TOP_OFFSET: begin
        ptr_hit = 1'b1;
        ptr_index = Q_OUT_POST;
      end
      OUT_POST_BOT_OFFSET: begin
        ptr_hit = 1'b1;
        ptr_is_bottom = 1'b1;
        ptr_index = Q_OUT_POST;
      end
      default: begin
        ptr_hit = 1'b0;
      end
    endcase
  end

  // Writes to the control word and to the pointer offset fields
  assign cs_write = reg_write && cs_hit;
  assign host_ofs = reg_wdata[BASE_LSB-1:OFS_LSB];

  // One host write strobe per pointer register
  always_comb begin
    host_wr_top = 4'h0;
    host_wr_bot = 4'h0;
    if (reg_write && ptr_hit) begin
      if (ptr_is_bottom) begin
        host_wr_bot[ptr_index] = 1'b1;
      end else begin
        host_wr_top[ptr_index] = 1'b1;
      end
    end
  end

  // Base address, only bits 31:20 are stored
  always_ff @(posedge mclk) begin
    if (rst) begin
      queue_region_base <= BASE_RESET;
    end else if (cs_write) begin
      queue_region_base <= reg_wdata[31:BASE_LSB];
    end
  end

  // Depth selector
  always_ff @(posedge mclk) begin
    if (rst) begin
      depth_code <= DEPTH_RESET;
    end else if (cs_write) begin
      depth_code <= reg_wdata[DEPTH_LSB+2:DEPTH_LSB];
    end
  end

  // Bottom-read mode bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      bottom_read_mode <= RDMODE_RESET;
    end else if (cs_write) begin
      bottom_read_mode <= reg_wdata[RDMODE_BIT];
    end
  end

  // Queue access control bit; 1 shuts the queue port
  always_ff @(posedge mclk) begin
    if (rst) begin
      queue_access_control <= ACCESS_RESET;
    end else if (cs_write) begin
      queue_access_control <= reg_wdata[ACCESS_BIT];
    end
  end

  // Queue port: kind equals queue index; free-in and post-out pop bottoms
  always_comb begin
    q_enabled = q_req.valid && !queue_access_control;
    q_is_pop = queue_pops(q_req.queue);
    if (q_is_pop) begin
      q_blocked = empty_flag[q_req.queue];
      q_entry = mqp_entry_addr(queue_region_base, bot_ptr[q_req.queue]);
    end else begin
      q_blocked = full_flag[q_req.queue];
      q_entry = mqp_entry_addr(queue_region_base, top_ptr[q_req.queue]);
    end
  end

  // A request is carried out only when enabled and not blocked
  assign q_accept = q_enabled && !q_blocked;

  // Advance strobes per queue; host-kept pointers never step
  always_comb begin
    advance_top = 4'h0;
    advance_bot = 4'h0;
    if (q_accept) begin
      if (q_is_pop) begin
        advance_bot[q_req.queue] = 1'b1;
      end else begin
        advance_top[q_req.queue] = 1'b1;
      end
    end
  end

  // Top pointers: host write wins over a same-cycle advance
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NUM_Q; i++) begin
        top_ptr[i] <= OFS_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_Q; i++) begin
        if (host_wr_top[i]) begin
          top_ptr[i] <= host_ofs;
        end else if (advance_top[i]) begin
          top_ptr[i] <= next_top_ptr[i];
        end
      end
    end
  end

  // Bottom pointers: host write wins over a same-cycle advance
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NUM_Q; i++) begin
        bot_ptr[i] <= OFS_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_Q; i++) begin
        if (host_wr_bot[i]) begin
          bot_ptr[i] <= host_ofs;
        end else if (advance_bot[i]) begin
          bot_ptr[i] <= next_bot_ptr[i];
        end
      end
    end
  end

  // Queue port answer, formed from the pre-advance pointer
  always_comb begin
    next_ans.done = q_req.valid;
    next_ans.ignored = q_req.valid && (queue_access_control || q_blocked);
    if (q_req.valid && !next_ans.ignored) begin
      next_ans.addr = q_entry;
    end else if (q_req.valid) begin
      next_ans.addr = ALL_ONES;
    end else begin
      next_ans.addr = READ_ZERO;
    end
  end

  // Answer register, one cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_ans <= '0;
    end else begin
      q_ans <= next_ans;
    end
  end

  // Control and status word as software reads it
  always_comb begin
    status_word = READ_ZERO;
    status_word[31:BASE_LSB] = queue_region_base;
    status_word[EMPTY_LSB+3:EMPTY_LSB] = flag_field(empty_flag);
    status_word[FULL_LSB+3:FULL_LSB] = flag_field(full_flag);
    status_word[DEPTH_LSB+2:DEPTH_LSB] = depth_code;
    status_word[RDMODE_BIT] = bottom_read_mode;
    status_word[ACCESS_BIT] = queue_access_control;
  end

  // Bottom pointer register view in the selected read mode
  assign bottom_view = bottom_read_value(bottom_read_mode, empty_flag[ptr_index],
    mqp_entry_addr(queue_region_base, bot_ptr[ptr_index]));

  // Read data selection
  always_comb begin
    next_rdata = READ_ZERO;
    if (cs_hit) begin
      next_rdata = status_word;
    end else if (ptr_hit && ptr_is_bottom) begin
      next_rdata = bottom_view;
    end else if (ptr_hit) begin
      next_rdata = mqp_entry_addr(queue_region_base, top_ptr[ptr_index]);
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

  // Host should set pointers before clearing the access bit; nothing enforced
endmodule

// >>> bench/mqp_regs_sva.sv
`timescale 1ns/1ps
module mqp_regs_sva #(
  parameter int ADDR_BITS = 12
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_BITS-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire mqp_pkg::mqp_q_req_type q_req,
  input wire mqp_pkg::mqp_q_ans_type q_ans,
  input wire logic [3:0] queue_empty,
  input wire logic [3:0] queue_full
);
  import mqp_pkg::*;
  // One clock domain, synchronous reset
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Base address as last written by software
  logic [11:0] base_seen;
  always_ff @(posedge mclk) begin
    if (rst) begin
      base_seen <= BASE_RESET;
    end else if (reg_write && reg_addr == CS_OFFSET) begin
      base_seen <= reg_wdata[31:BASE_LSB];
    end
  end
  AST_DONE: assert property (q_req.valid |=> q_ans.done)
    else $error("queue request not answered");
  AST_IDLE: assert property (!q_req.valid |=> !q_ans.done && q_ans.addr == 32'h0)
    else $error("answer without request");
  AST_REFUSE: assert property (q_ans.done && q_ans.ignored |-> q_ans.addr == ALL_ONES)
    else $error("refused answer not all ones");
  AST_OFF: assert property (reg_write && reg_addr == CS_OFFSET && reg_wdata[ACCESS_BIT] ##1 !reg_write
    ##1 q_req.valid |=> q_ans.ignored)
    else $error("request taken while disabled");
  AST_ALIGN: assert property (q_ans.done && !q_ans.ignored |-> q_ans.addr[1:0] == 2'b00
    && q_ans.addr[31:20] == $past(base_seen))
    else $error("entry address not base plus word offset");
  AST_EXCL: assert property ((queue_empty & queue_full) == 4'h0)
    else $error("queue both empty and full");
  AST_RSTV: assert property ($past(rst) |-> queue_empty == 4'hf && queue_full == 4'h0)
    else $error("flags wrong after reset");
  AST_FLAGS: assert property (reg_read && reg_addr == CS_OFFSET |=>
    {reg_rdata[12], reg_rdata[13], reg_rdata[14], reg_rdata[15]} == $past(queue_empty)
    && {reg_rdata[8], reg_rdata[9], reg_rdata[10], reg_rdata[11]} == $past(queue_full))
    else $error("status flags misreported");
  AST_RDZ: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule

// >>> bench/mqp_agent.sv
`timescale 1ns/1ps
module mqp_agent (
  input wire logic mclk,
  output mqp_pkg::mqp_q_req_type q_req,
  input wire mqp_pkg::mqp_q_ans_type q_ans
);
  import mqp_pkg::*;
  // Idle bus at start
  initial q_req = '0;
  // One request; released queue field shows the inverse value
  task automatic push(input logic [1:0] q, output mqp_q_ans_type a);
    @(posedge mclk);
    q_req <= {1'b1, q};
    @(posedge mclk);
    q_req <= {1'b0, ~q};
    #1;
    a = q_ans;
  endtask
endmodule

// >>> bench/mqp_regs_bench.sv
`timescale 1ns/1ps
module mqp_regs_bench;
  import mqp_pkg::*;
  localparam logic [31:0] B = 32'h12300000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  mqp_q_req_type q_req;
  mqp_q_ans_type q_ans;
  logic [3:0] queue_empty;
  logic [3:0] queue_full;
  int fails = 0;
  int compares = 0;
  logic [31:0] m;
  // Clock, 50 ns period
  always #25 mclk = ~mclk;
  mqp_regs DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .q_req(q_req),
    .q_ans(q_ans), .queue_empty(queue_empty), .queue_full(queue_full));
  mqp_agent u_agent (.mclk(mclk), .q_req(q_req), .q_ans(q_ans));
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    chk("rdata", {2'b00, reg_rdata}, {2'b00, e});
  endtask
  task automatic rq(input logic [1:0] q, input logic [33:0] e);
    mqp_q_ans_type a;
    u_agent.push(q, a);
    chk("answer", {a.done, a.ignored, a.addr}, e);
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(CS_OFFSET, 32'h0000f000);
    rd(12'h300, 32'h0);
    $display("reset test done");
    wr(CS_OFFSET, B);
    rd(IN_FREE_TOP_OFFSET, B);
    wr(IN_FREE_TOP_OFFSET, 32'hfff00010);
    rd(IN_FREE_TOP_OFFSET, B | 32'h10);
    $display("base test done");
    rq(Q_IN_POST, {2'b10, B});
    rd(IN_POST_TOP_OFFSET, B | 32'h4);
    chk("empty", {30'h0, queue_empty}, 34'hc);
    rd(CS_OFFSET, B | 32'h00003000);
    wr(IN_POST_BOT_OFFSET, 32'h4);
    rd(IN_POST_BOT_OFFSET, B | 32'h4);
    chk("empty", {30'h0, queue_empty}, 34'he);
    $display("post test done");
    wr(CS_OFFSET, B | 32'h2);
    rd(IN_FREE_BOT_OFFSET, B);
    wr(IN_FREE_BOT_OFFSET, 32'h10);
    rd(IN_FREE_BOT_OFFSET, ALL_ONES);
    wr(CS_OFFSET, B);
    rd(IN_FREE_BOT_OFFSET, B | 32'h10);
    $display("bottom mode test done");
    wr(IN_FREE_BOT_OFFSET, 32'h3fc);
    wr(IN_FREE_TOP_OFFSET, 32'h4);
    rq(Q_IN_FREE, {2'b10, B | 32'h3fc});
    rd(IN_FREE_BOT_OFFSET, B);
    rq(Q_IN_FREE, {2'b10, B});
    rq(Q_IN_FREE, {2'b11, ALL_ONES});
    $display("pop wrap test done");
    wr(OUT_POST_TOP_OFFSET, 32'h8);
    rq(Q_OUT_POST, {2'b10, B});
    rq(Q_OUT_POST, {2'b10, B | 32'h4});
    rq(Q_OUT_POST, {2'b11, ALL_ONES});
    rd(OUT_POST_BOT_OFFSET, B | 32'h8);
    rd(OUT_POST_TOP_OFFSET, B | 32'h8);
    $display("out post test done");
    // Code 5 is reserved and acts as the smallest size
    for (int d = 0; d < 6; d++) begin
      m = (d < 5) ? (32'h400 << (2 * d)) - 32'h4 : 32'h3fc;
      wr(CS_OFFSET, B | (d << 4));
      wr(OUT_FREE_BOT_OFFSET, 32'h4);
      wr(OUT_FREE_TOP_OFFSET, m);
      rq(Q_OUT_FREE, {2'b10, B | m});
      rd(OUT_FREE_TOP_OFFSET, B);
      chk("full", {30'h0, queue_full}, 34'h4);
      rq(Q_OUT_FREE, {2'b11, ALL_ONES});
    end
    $display("depth test done");
    wr(CS_OFFSET, B | 32'h1);
    rq(Q_IN_POST, {2'b11, ALL_ONES});
    rd(IN_POST_TOP_OFFSET, B | 32'h4);
    wr(CS_OFFSET, B);
    rq(Q_IN_POST, {2'b10, B | 32'h4});
    $display("access test done");
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    stop_test();
  end
endmodule
bind mqp_regs mqp_regs_sva #(.ADDR_BITS(ADDR_BITS)) u_sva (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .q_req(q_req), .q_ans(q_ans), .queue_empty(queue_empty), .queue_full(queue_full));
